//--- verilog/gpp_pkg.sv
// Constants, types and register map of the general purpose port block.
// Assumes one clock, a synchronous active-high reset and an 8-bit register port.

package gpp_pkg;

  localparam int unsigned NUM_IO = 13;
  localparam int unsigned AW     = 8;
  localparam int unsigned DW     = 8;

  // Register offsets
  localparam logic [7:0] OFS_P2_DATA   = 8'h00;
  localparam logic [7:0] OFS_P3_DATA   = 8'h01;
  localparam logic [7:0] OFS_P4_DATA   = 8'h02;
  localparam logic [7:0] OFS_P2_DIR    = 8'h03;
  localparam logic [7:0] OFS_P3_DIR    = 8'h04;
  localparam logic [7:0] OFS_P4_DIR    = 8'h05;
  localparam logic [7:0] OFS_P2_ANALOG = 8'h06;
  localparam logic [7:0] OFS_P2_PULLUP = 8'h07;
  localparam logic [7:0] OFS_P3_PULLUP = 8'h08;
  localparam logic [7:0] OFS_P4_PULLUP = 8'h09;
  localparam logic [7:0] OFS_STATUS    = 8'h0a;

  // Bit positions inside the 13-bit flat pad vector
  localparam int unsigned P2_LSB = 0;
  localparam int unsigned P3_BIT = 4;
  localparam int unsigned P4_LSB = 5;
  localparam int unsigned OSC_B  = 2;
  localparam int unsigned OSC_A  = 3;

  // Field positions inside registers
  localparam int unsigned P3_IO_POS  = 2;
  localparam int unsigned P3_IN_POS  = 4;

  // Reset values
  localparam logic [12:0] DIR_RST    = 13'h1fff;
  localparam logic [12:0] LATCH_RST  = 13'h0000;
  localparam logic [12:0] PULLUP_RST = 13'h0000;
  localparam logic [3:0]  ANALOG_RST = 4'h0;

  // Option byte layout and oscillator codes
  localparam int unsigned OPT_OSC_LSB  = 0;
  localparam int unsigned OPT_RSTP_POS = 2;
  localparam logic [1:0]  OSC_INTERNAL = 2'h0;
  localparam logic [1:0]  OSC_CRYSTAL  = 2'h1;
  localparam logic [1:0]  OSC_EXTCLK   = 2'h2;

  typedef enum logic [1:0] {
    OSC_MODE_INT,
    OSC_MODE_XTAL,
    OSC_MODE_EXT
  } gpp_osc_type;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_LOAD,
    ST_RUN
  } gpp_state_type;

  typedef struct packed {
    logic [12:0] out;
    logic [12:0] oe;
    logic [12:0] pu;
  } gpp_pad_type;

  typedef struct packed {
    gpp_osc_type osc;
    logic        rst_pin_is_port;
  } gpp_option_type;

  function automatic gpp_osc_type decode_osc(input logic [1:0] code);
    unique case (code)
      OSC_CRYSTAL: decode_osc = OSC_MODE_XTAL;
      OSC_EXTCLK:  decode_osc = OSC_MODE_EXT;
      default:     decode_osc = OSC_MODE_INT;
    endcase
  endfunction

endpackage

//--- verilog/gpp_pad_ctrl.sv
// Per-pin pad control for the thirteen bidirectional port pins.
// Assumes latch, direction and pull-up state come registered from the parent.
`timescale 1ns/1ps

module gpp_pad_ctrl (
  input  wire logic [12:0]        latch,     // Output latches
  input  wire logic [12:0]        dir,       // One means input
  input  wire logic [12:0]        pu,        // Pull-up enables
  input  wire logic [12:0]        usable,    // Pin free for port use
  input  wire logic [12:0]        analog,    // Pin routed to converter
  input  wire logic [12:0]        pin_in,    // Pin levels
  input  wire logic [12:0]        alt_en,    // Peripheral output enables
  input  wire logic [12:0]        alt_out,   // Peripheral output values
  output gpp_pkg::gpp_pad_type    pad_d,     // Next pad drive
  output logic      [12:0]        rd_val     // Readback per pin
);

  logic [12:0] digital;

  always_comb begin
    digital    = usable & ~analog;
    pad_d.oe   = digital & ~dir;
    pad_d.out  = latch | (alt_en & alt_out);
    pad_d.pu   = digital & dir & pu;
    rd_val     = digital & ((dir & pin_in) | (~dir & latch));
  end

endmodule // gpp_pad_ctrl

//--- verilog/gpp_port_top.sv
// General purpose port block: ports 2, 3 and 4 with register port.
// Assumes synchronous pin inputs, option byte stable from reset release.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

module gpp_port_top (
  input  wire logic        ref_clk,            // 200 MHz clock
  input  wire logic        rst,                // Synchronous reset, high
  input  wire logic [7:0]  addr,               // Register address
  input  wire logic [7:0]  wr_data,            // Write data
  input  wire logic        wr_en,              // Write strobe
  input  wire logic        rd_en,              // Read strobe
  output logic      [7:0]  rd_data,            // Read data, next cycle
  input  wire logic [7:0]  option_byte,        // Nonvolatile option byte
  input  wire logic [3:0]  port2_pins_in,      // Port 2 pin levels
  output logic      [3:0]  port2_pins_out,     // Port 2 output values
  output logic      [3:0]  port2_pins_oe,      // Port 2 driver enables
  output logic      [3:0]  port2_pins_pu,      // Port 2 pull-up enables
  output logic      [3:0]  port2_analog_en,    // Port 2 routed to converter
  output logic      [3:0]  port2_alt_in,       // Port 2 levels to timers and interrupts
  input  wire logic [3:0]  port2_alt_out,      // Timer output values
  input  wire logic [3:0]  port2_alt_out_en,   // Timer output enables
  output logic      [1:0]  osc_pin_claimed,    // Shared pins given to oscillator, [1]=pin a
  output logic      [1:0]  osc_pin_pulldown,   // Reset pull-downs, [1]=pin a
  input  wire logic        port3_io_pin_in,    // Port 3 io pin level
  output logic             port3_io_pin_out,   // Port 3 io output value
  output logic             port3_io_pin_oe,    // Port 3 io driver enable
  output logic             port3_io_pin_pu,    // Port 3 io pull-up enable
  output logic             ext_interrupt_input_1, // Port 3 io level to interrupt logic
  input  wire logic        reset_shared_input_pin, // Reset-shared input pin level
  output logic             sys_reset_hold,     // Holds chip in reset
  input  wire logic [7:0]  port4_pins_in,      // Port 4 pin levels
  output logic      [7:0]  port4_pins_out,     // Port 4 output values
  output logic      [7:0]  port4_pins_oe,      // Port 4 driver enables
  output logic      [7:0]  port4_pins_pu       // Port 4 pull-up enables
);

  // Register state
  logic [12:0]              latch_q, latch_d;
  logic [12:0]              dir_q, dir_d;
  logic [12:0]              pu_q, pu_d;
  logic [3:0]               analog_q, analog_d;
  gpp_pkg::gpp_option_type  opt_q, opt_d;
  gpp_pkg::gpp_state_type   st_q, st_d;

  // Output flops
  gpp_pkg::gpp_pad_type     pad_q, pad_d;
  logic [3:0]               analog_en_q, analog_en_d;
  logic [3:0]               alt_in_q, alt_in_d;
  logic [1:0]               claimed_q, claimed_d;
  logic [1:0]               pulldown_q, pulldown_d;
  logic                     int1_q, int1_d;
  logic                     hold_q, hold_d;
  logic [7:0]               rd_data_q, rd_data_d;

  // Combinational helpers
  logic [12:0]              usable;
  logic [12:0]              analog13;
  logic [12:0]              pin_in13;
  logic [12:0]              alt_en13;
  logic [12:0]              alt_out13;
  logic [12:0]              rd_val;
  logic                     bus_ok;

  // Unpacks a register write into flat pad vector fields
  function automatic logic [12:0] merge_reg(input logic [12:0] cur, input logic [7:0] offs,
                                            input logic [7:0] data, input logic [7:0] base);
    logic [12:0] nxt;
    nxt = cur;
    if (offs == base) begin
      nxt[gpp_pkg::P2_LSB +: 4] = data[3:0];
    end else if (offs == base + 8'h01) begin
      nxt[gpp_pkg::P3_BIT] = data[gpp_pkg::P3_IO_POS];
    end else if (offs == base + 8'h02) begin
      nxt[gpp_pkg::P4_LSB +: 8] = data;
    end
    return nxt;
  endfunction

  // Packs one port's bits of a flat vector into its register image
  function automatic logic [7:0] pack_reg(input logic [12:0] v, input logic [1:0] port,
                                          input logic fill);
    logic [7:0] r;
    r = {8{fill}};
    unique case (port)
      2'h0:    r[3:0] = v[gpp_pkg::P2_LSB +: 4];
      2'h1:    r[gpp_pkg::P3_IO_POS] = v[gpp_pkg::P3_BIT];
      default: r = v[gpp_pkg::P4_LSB +: 8];
    endcase
    return r;
  endfunction

  // Pin availability from the oscillator choice
  always_comb begin
    usable = '1;
    unique case (opt_q.osc)
      gpp_pkg::OSC_MODE_XTAL: begin
        usable[gpp_pkg::OSC_A] = 1'b0;
        usable[gpp_pkg::OSC_B] = 1'b0;
      end
      gpp_pkg::OSC_MODE_EXT: begin
        usable[gpp_pkg::OSC_A] = 1'b0;
      end
      gpp_pkg::OSC_MODE_INT: begin
        usable = '1;
      end
    endcase
    if (st_q != gpp_pkg::ST_RUN) begin
      usable = '0;
    end
    analog13  = {9'h000, analog_q};
    pin_in13  = {port4_pins_in, port3_io_pin_in, port2_pins_in};
    alt_en13  = {9'h000, port2_alt_out_en};
    alt_out13 = {9'h000, port2_alt_out};
  end

  gpp_pad_ctrl u_pad (
    .latch   (latch_q),
    .dir     (dir_q),
    .pu      (pu_q),
    .usable  (usable),
    .analog  (analog13),
    .pin_in  (pin_in13),
    .alt_en  (alt_en13),
    .alt_out (alt_out13),
    .pad_d   (pad_d),
    .rd_val  (rd_val)
  );

  // Start-up sequence, option byte and reset pin
  always_comb begin
    st_d  = st_q;
    opt_d = opt_q;
    unique case (st_q)
      gpp_pkg::ST_RESET: begin
        st_d = gpp_pkg::ST_LOAD;
      end
      gpp_pkg::ST_LOAD: begin
        if (reset_shared_input_pin) begin
          opt_d.osc             = gpp_pkg::decode_osc(option_byte[gpp_pkg::OPT_OSC_LSB +: 2]);
          opt_d.rst_pin_is_port = option_byte[gpp_pkg::OPT_RSTP_POS];
          st_d                  = gpp_pkg::ST_RUN;
        end
      end
      gpp_pkg::ST_RUN: begin
        st_d = gpp_pkg::ST_RUN;
      end
    endcase
    // Reset function stays on until the option byte has made the pin a port
    hold_d = (st_q != gpp_pkg::ST_RUN) ||
             (!opt_q.rst_pin_is_port && !reset_shared_input_pin);
  end

  // Register writes and reads
  always_comb begin
    bus_ok   = (st_q == gpp_pkg::ST_RUN);
    latch_d  = latch_q;
    dir_d    = dir_q;
    pu_d     = pu_q;
    analog_d = analog_q;
    if (wr_en && bus_ok) begin
      latch_d = merge_reg(latch_q, addr, wr_data, gpp_pkg::OFS_P2_DATA);
      dir_d   = merge_reg(dir_q, addr, wr_data, gpp_pkg::OFS_P2_DIR);
      pu_d    = merge_reg(pu_q, addr, wr_data, gpp_pkg::OFS_P2_PULLUP);
      if (addr == gpp_pkg::OFS_P2_ANALOG) begin
        analog_d = wr_data[3:0];
      end
    end
    rd_data_d = 8'h00;
    if (rd_en) begin
      unique case (addr)
        gpp_pkg::OFS_P2_DATA:   rd_data_d = pack_reg(rd_val, 2'h0, 1'b0);
        gpp_pkg::OFS_P3_DATA: begin
          rd_data_d = pack_reg(rd_val, 2'h1, 1'b0);
          rd_data_d[gpp_pkg::P3_IN_POS] = opt_q.rst_pin_is_port & reset_shared_input_pin;
        end
        gpp_pkg::OFS_P4_DATA:   rd_data_d = pack_reg(rd_val, 2'h2, 1'b0);
        gpp_pkg::OFS_P2_DIR:    rd_data_d = pack_reg(dir_q, 2'h0, 1'b1);
        gpp_pkg::OFS_P3_DIR:    rd_data_d = pack_reg(dir_q, 2'h1, 1'b1);
        gpp_pkg::OFS_P4_DIR:    rd_data_d = pack_reg(dir_q, 2'h2, 1'b1);
        gpp_pkg::OFS_P2_ANALOG: rd_data_d = {4'h0, analog_q};
        gpp_pkg::OFS_P2_PULLUP: rd_data_d = pack_reg(pu_q, 2'h0, 1'b0);
        gpp_pkg::OFS_P3_PULLUP: rd_data_d = pack_reg(pu_q, 2'h1, 1'b0);
        gpp_pkg::OFS_P4_PULLUP: rd_data_d = pack_reg(pu_q, 2'h2, 1'b0);
        gpp_pkg::OFS_STATUS:    rd_data_d = {4'h0, hold_q, opt_q.rst_pin_is_port, opt_q.osc};
        default:                rd_data_d = 8'h00;
      endcase
    end
  end

  // Peripheral side outputs
  always_comb begin
    analog_en_d = analog_q & usable[3:0];
    alt_in_d    = port2_pins_in & usable[3:0] & ~analog_q;
    int1_d      = port3_io_pin_in & usable[gpp_pkg::P3_BIT];
    claimed_d   = ~usable[gpp_pkg::OSC_A:gpp_pkg::OSC_B] & {2{st_q == gpp_pkg::ST_RUN}};
    pulldown_d  = 2'b00;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      latch_q     <= gpp_pkg::LATCH_RST;
      dir_q       <= gpp_pkg::DIR_RST;
      pu_q        <= gpp_pkg::PULLUP_RST;
      analog_q    <= gpp_pkg::ANALOG_RST;
      opt_q       <= '{osc: gpp_pkg::OSC_MODE_INT, rst_pin_is_port: 1'b0};
      st_q        <= gpp_pkg::ST_RESET;
      pad_q       <= '0;
      analog_en_q <= 4'h0;
      alt_in_q    <= 4'h0;
      claimed_q   <= 2'b00;
      pulldown_q  <= 2'b11;
      int1_q      <= 1'b0;
      hold_q      <= 1'b1;
      rd_data_q   <= 8'h00;
    end else begin
      latch_q     <= latch_d;
      dir_q       <= dir_d;
      pu_q        <= pu_d;
      analog_q    <= analog_d;
      opt_q       <= opt_d;
      st_q        <= st_d;
      pad_q       <= pad_d;
      analog_en_q <= analog_en_d;
      alt_in_q    <= alt_in_d;
      claimed_q   <= claimed_d;
      pulldown_q  <= pulldown_d;
      int1_q      <= int1_d;
      hold_q      <= hold_d;
      rd_data_q   <= rd_data_d;
    end
  end

  // Thirteen driven pins plus one input-only pin
  always_comb begin
    port2_pins_out        = pad_q.out[3:0];
    port2_pins_oe         = pad_q.oe[3:0];
    port2_pins_pu         = pad_q.pu[3:0];
    port3_io_pin_out      = pad_q.out[gpp_pkg::P3_BIT];
    port3_io_pin_oe       = pad_q.oe[gpp_pkg::P3_BIT];
    port3_io_pin_pu       = pad_q.pu[gpp_pkg::P3_BIT];
    port4_pins_out        = pad_q.out[12:5];
    port4_pins_oe         = pad_q.oe[12:5];
    port4_pins_pu         = pad_q.pu[12:5];
    port2_analog_en       = analog_en_q;
    port2_alt_in          = alt_in_q;
    osc_pin_claimed       = claimed_q;
    osc_pin_pulldown      = pulldown_q;
    ext_interrupt_input_1 = int1_q;
    sys_reset_hold        = hold_q;
    rd_data               = rd_data_q;
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_release;
    rst ##1 !rst;
  endsequence

  sequence s_load_low;
    (st_q == gpp_pkg::ST_LOAD) && !reset_shared_input_pin;
  endsequence

  a_reset_pulldown: assert property (disable iff (1'b0) rst |=> osc_pin_pulldown == 2'b11)
    else $error("oscillator pins not pulled down in reset");
  a_reset_dir_input: assert property (disable iff (1'b0) rst |=> dir_q == gpp_pkg::DIR_RST)
    else $error("direction not input after reset");
  a_release_hold: assert property (disable iff (1'b0) s_release |-> sys_reset_hold)
    else $error("reset hold dropped at release");
  a_load_low_hold: assert property (s_load_low |=> st_q == gpp_pkg::ST_LOAD ##1 sys_reset_hold)
    else $error("low reset pin did not hold reset");
  a_xtal_pins_off: assert property ((st_q == gpp_pkg::ST_RUN && opt_q.osc == gpp_pkg::OSC_MODE_XTAL)
                                    |=> pad_q.oe[3:2] == 2'b00 && pad_q.pu[3:2] == 2'b00)
    else $error("crystal pins used as port");
  a_ext_pin_a_off: assert property ((st_q == gpp_pkg::ST_RUN && opt_q.osc == gpp_pkg::OSC_MODE_EXT)
                                    |=> !pad_q.oe[3] && !port2_analog_en[3])
    else $error("external clock pin used as port");
  a_output_enable: assert property ((st_q == gpp_pkg::ST_RUN && opt_q.osc == gpp_pkg::OSC_MODE_INT)
                                    |=> pad_q.oe == (~$past(dir_q) & ~{9'h000, $past(analog_q)}))
    else $error("driver enable does not follow direction");
  a_pullup_input: assert property (1'b1 |=> (pad_q.pu & ~$past(dir_q)) == 13'h0000)
    else $error("pull-up on output pin");
  a_read_port4: assert property ((rd_en && addr == gpp_pkg::OFS_P4_DATA && st_q == gpp_pkg::ST_RUN)
                                 |=> rd_data == (($past(dir_q[12:5]) & $past(port4_pins_in)) |
                                                 (~$past(dir_q[12:5]) & $past(latch_q[12:5]))))
    else $error("port 4 read value wrong");
  a_unused_zero: assert property ((rd_en && addr == gpp_pkg::OFS_P2_DATA) |=> rd_data[7:4] == 4'h0)
    else $error("unimplemented data bits not zero");
  a_analog_off: assert property ((st_q == gpp_pkg::ST_RUN && analog_q[0]) |=> !pad_q.oe[0] && !pad_q.pu[0])
    else $error("analog pin still digital");

  // Run-time views used by the checks below
  sequence s_run_int;
    (st_q == gpp_pkg::ST_RUN) && (opt_q.osc == gpp_pkg::OSC_MODE_INT);
  endsequence

  sequence s_run_xtal;
    (st_q == gpp_pkg::ST_RUN) && (opt_q.osc == gpp_pkg::OSC_MODE_XTAL);
  endsequence

  sequence s_run_ext;
    (st_q == gpp_pkg::ST_RUN) && (opt_q.osc == gpp_pkg::OSC_MODE_EXT);
  endsequence

  sequence s_run_port_pin;
    (st_q == gpp_pkg::ST_RUN) && opt_q.rst_pin_is_port;
  endsequence

  a_pulldown_release: assert property (1'b1 |=> osc_pin_pulldown == 2'b00)
    else $error("oscillator pins still pulled down after reset");
  a_int_pins_free: assert property (s_run_int |=> osc_pin_claimed == 2'b00)
    else $error("internal oscillator claims shared pins");
  a_xtal_claimed: assert property (s_run_xtal |=> osc_pin_claimed == 2'b11)
    else $error("crystal pins not claimed");
  a_ext_pin_b_free: assert property (s_run_ext |=> osc_pin_claimed == 2'b10)
    else $error("external clock claims wrong pins");
  a_option_taken: assert property ((st_q == gpp_pkg::ST_LOAD && reset_shared_input_pin)
                                   |=> st_q == gpp_pkg::ST_RUN &&
                                       opt_q.rst_pin_is_port == $past(option_byte[gpp_pkg::OPT_RSTP_POS]))
    else $error("option byte not taken at load");
  a_out_from_latch: assert property (1'b1 |=> pad_q.out == ($past(latch_q) |
                                     {9'h000, $past(port2_alt_out_en) & $past(port2_alt_out)}))
    else $error("output value does not follow latch");
  a_alt_in_levels: assert property (s_run_int |=>
                                    port2_alt_in == ($past(port2_pins_in) & ~$past(analog_q)))
    else $error("peripheral input levels wrong");
  a_quiet_before_run: assert property ((st_q != gpp_pkg::ST_RUN) |=>
                                       pad_q.oe == 13'h0000 && pad_q.pu == 13'h0000)
    else $error("pin driven before start-up finished");
  a_int1_level: assert property ((st_q == gpp_pkg::ST_RUN) |=>
                                 ext_interrupt_input_1 == $past(port3_io_pin_in))
    else $error("interrupt input does not follow pin");
  a_in_pin_zero: assert property ((rd_en && addr == gpp_pkg::OFS_P3_DATA && !opt_q.rst_pin_is_port)
                                  |=> !rd_data[gpp_pkg::P3_IN_POS])
    else $error("reset pin read as port bit");
  a_hold_in_load: assert property ((st_q != gpp_pkg::ST_RUN) |=> sys_reset_hold)
    else $error("reset released before option byte read");
  a_reset_pin_hold: assert property ((st_q == gpp_pkg::ST_RUN && !opt_q.rst_pin_is_port &&
                                      !reset_shared_input_pin) |=> sys_reset_hold)
    else $error("low reset pin did not reset");
  a_port_pin_free: assert property (s_run_port_pin |=> !sys_reset_hold)
    else $error("port pin still acts as reset");
  a_p4_pullup: assert property ((st_q == gpp_pkg::ST_RUN) |=>
                                pad_q.pu[12:5] == ($past(dir_q[12:5]) & $past(pu_q[12:5])))
    else $error("port 4 pull-up wrong");

endmodule // gpp_port_top

//--- dv/gpp_pin_model.sv
// Board-side model of the wires on the thirteen bidirectional port pins.
// Assumes pad outputs of the port block; the bench supplies any board drive.
`timescale 1ns/1ps

module gpp_pin_model (
  input  wire logic        clk,     // Block clock
  input  wire logic [12:0] out,     // Pad output values
  input  wire logic [12:0] oe,      // Pad driver enables
  input  wire logic [12:0] pu,      // Pad pull-up enables
  input  wire logic [12:0] ext_en,  // Board driver enables
  input  wire logic [12:0] ext_val, // Board driver values
  output logic      [12:0] pin      // Resolved wire levels
);
  logic [12:0] float_q = 13'h0000;

  // Undriven wires without pull-up toggle every cycle so no stale level can pass
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end

  assign pin = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pu | float_q));
endmodule // gpp_pin_model

//--- dv/testbench.sv
// Self-checking bench for the port block: register tasks and pad checks.
// Assumes the port block and the board pin model under dv/.
`timescale 1ns/1ps

module testbench;
  logic        ref_clk     = 1'b0;
  logic        rst         = 1'b1;
  logic [7:0]  addr        = 8'h00;
  logic [7:0]  wr_data     = 8'h00;
  logic        wr_en       = 1'b0;
  logic        rd_en       = 1'b0;
  logic [7:0]  option_byte = 8'h00;
  logic        rs_pin      = 1'b1;
  logic [12:0] ext_en      = 13'h0000;
  logic [12:0] ext_val     = 13'h0000;
  logic [7:0]  rd_data;
  logic [7:0]  q;
  logic [3:0]  p2_out, p2_oe, p2_pu, p2_an;
  logic [3:0]  p2_alt;
  logic [3:0]  alt_out     = 4'ha;
  logic [3:0]  alt_en      = 4'h0;
  logic        p3_out, p3_oe, p3_pu, int1, hold;
  logic [7:0]  p4_out, p4_oe, p4_pu;
  logic [1:0]  claimed, pdown;
  logic [12:0] pin;
  int          failures    = 0;
  int          comparisons = 0;

  always #2.5 ref_clk = ~ref_clk;

  gpp_port_top gpp_port_top_i (
    .ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .option_byte(option_byte), .port2_pins_in(pin[3:0]), .port2_pins_out(p2_out),
    .port2_pins_oe(p2_oe), .port2_pins_pu(p2_pu), .port2_analog_en(p2_an), .port2_alt_in(p2_alt),
    .port2_alt_out(alt_out), .port2_alt_out_en(alt_en), .osc_pin_claimed(claimed), .osc_pin_pulldown(pdown),
    .port3_io_pin_in(pin[4]), .port3_io_pin_out(p3_out), .port3_io_pin_oe(p3_oe), .port3_io_pin_pu(p3_pu),
    .ext_interrupt_input_1(int1), .reset_shared_input_pin(rs_pin), .sys_reset_hold(hold),
    .port4_pins_in(pin[12:5]), .port4_pins_out(p4_out), .port4_pins_oe(p4_oe), .port4_pins_pu(p4_pu)
  );

  gpp_pin_model gpp_pin_model_i (
    .clk(ref_clk), .out({p4_out, p3_out, p2_out}), .oe({p4_oe, p3_oe, p2_oe}),
    .pu({p4_pu, p3_pu, p2_pu}), .ext_en(ext_en), .ext_val(ext_val), .pin(pin)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge ref_clk);
    wr_en   <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    q = rd_data;
  endtask

  // Pads follow register writes two edges later
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic do_reset(input logic [7:0] opt);
    @(posedge ref_clk);
    option_byte <= opt;
    rst         <= 1'b1;
    repeat (12) @(posedge ref_clk);
    #1;
    chk(pdown, 2'b11);
    chk({p4_oe, p3_oe, p2_oe, p4_pu, p3_pu, p2_pu}, 26'h0);
    @(posedge ref_clk);
    rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    chk(hold, !rs_pin);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    do_reset(8'h00);
    for (int a = 3; a < 10; a++) begin
      rd(8'(a));
      chk(q, (a < 6) ? 8'hff : 8'h00);
    end
    rd(8'h0b);
    chk(q, 8'h00);
    $display("test reset values done");
    wr(gpp_pkg::OFS_P4_DATA, 8'ha5);
    wr(gpp_pkg::OFS_P4_PULLUP, 8'hff);
    wr(gpp_pkg::OFS_P4_DIR, 8'h0f);
    ext_en  <= 13'h0060;
    ext_val <= 13'h0040;
    settle;
    chk({p4_oe, p4_out[7:4]}, 12'hf0a);
    chk(p4_pu, 8'h0f);
    rd(gpp_pkg::OFS_P4_DATA);
    chk(q, 8'hae);
    $display("test port 4 done");
    wr(gpp_pkg::OFS_P2_DATA, 8'hff);
    wr(gpp_pkg::OFS_P2_ANALOG, 8'h01);
    wr(gpp_pkg::OFS_P2_DIR, 8'h00);
    settle;
    chk({claimed, p2_oe, p2_an}, 10'h0e1);
    chk({p2_alt, p2_pu, p2_out}, 12'he0f);
    rd(gpp_pkg::OFS_P2_DATA);
    chk(q, 8'h0e);
    $display("test port 2 done");
    wr(gpp_pkg::OFS_P3_DATA, 8'hff);
    wr(gpp_pkg::OFS_P3_DIR, 8'hfb);
    settle;
    chk({p3_oe, p3_out}, 2'b11);
    rd(gpp_pkg::OFS_P3_DATA);
    chk(q, 8'h04);
    wr(gpp_pkg::OFS_P3_PULLUP, 8'h04);
    wr(gpp_pkg::OFS_P3_DIR, 8'hff);
    ext_en  <= 13'h0010;
    ext_val <= 13'h0000;
    settle;
    chk({p3_oe, p3_pu, int1}, 3'b010);
    ext_en <= 13'h0000;
    settle;
    chk(int1, 1'b1);
    rs_pin <= 1'b0;
    settle;
    chk(hold, 1'b1);
    $display("test port 3 done");
    do_reset(8'h00);
    rs_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    chk(hold, 1'b0);
    $display("test held reset done");
    alt_en <= 4'h3;
    for (int c = 0; c < 4; c++) begin
      do_reset({6'h01, 2'(c)});
      rd(gpp_pkg::OFS_STATUS);
      chk(q, {6'h01, (c == 3) ? 2'h0 : 2'(c)});
      wr(gpp_pkg::OFS_P2_DIR, 8'h00);
      settle;
      chk(claimed, (c == 1) ? 2'b11 : (c == 2) ? 2'b10 : 2'b00);
      chk(p2_oe, (c == 1) ? 4'h3 : (c == 2) ? 4'h7 : 4'hf);
      chk(p2_out, 4'h2);
    end
    rs_pin <= 1'b0;
    settle;
    rd(gpp_pkg::OFS_P3_DATA);
    chk({hold, q[4]}, 2'b00);
    rs_pin <= 1'b1;
    settle;
    rd(gpp_pkg::OFS_P3_DATA);
    chk(q[4], 1'b1);
    $display("test oscillator and shared pin done");
    tally_and_finish;
  end

  initial begin
    #50000;
    failures++;
    tally_and_finish;
  end
endmodule // testbench
